// File: hdl/ob_cal_pkg.sv
package ob_cal_pkg;
   // register byte offsets
   localparam logic [7:0] ADDR_CTRL       = 8'h00;
   localparam logic [7:0] ADDR_CTRL2      = 8'h04;
   localparam logic [7:0] ADDR_TARGET     = 8'h08;
   localparam logic [7:0] ADDR_HOT        = 8'h0c;
   localparam logic [7:0] ADDR_COLD       = 8'h10;
   localparam logic [7:0] ADDR_FINE_DAC   = 8'h14;
   localparam logic [7:0] ADDR_COARSE_DAC = 8'h18;
   localparam logic [7:0] ADDR_STATUS     = 8'h1c;
   localparam logic [7:0] ADDR_AVERAGE    = 8'h20;
   // ctrl fields
   localparam int CTRL_BYPASS_BIT   = 0;
   // ctrl2 fields
   localparam int CTRL2_WEIGHT_LSB  = 0;
   localparam int CTRL2_NPIX_LSB    = 4;
   localparam int CTRL2_SOF_BIT     = 8;
   // widths
   localparam int PIX_W    = 10;
   localparam int FINE_W   = 9;
   localparam int COARSE_W = 8;
   localparam int AVG_W    = PIX_W + 7;
   // reset values and ctrl2 field maxima
   localparam logic [PIX_W-1:0]    TARGET_RST  = 10'h040;
   localparam logic [PIX_W-1:0]    HOT_RST     = 10'h3ff;
   localparam logic [PIX_W-1:0]    COLD_RST    = 10'h000;
   localparam logic [2:0]          WEIGHT_RST  = 3'h0;
   localparam logic [2:0]          NPIX_RST    = 3'h4;
   localparam logic [2:0]          WEIGHT_MAX  = 3'h7;
   localparam logic [2:0]          NPIX_MAX    = 3'h6;
   localparam logic [FINE_W-1:0]   FINE_RST    = 9'h000;
   localparam logic [COARSE_W-1:0] COARSE_RST  = 8'h00;
   // fine dac span, converter lsbs
   localparam int FINE_SPAN = 225;

   typedef struct packed {
      logic             sof_fast;
      logic [2:0]       npix_log2;
      logic [2:0]       weight_shift;
      logic             bypass;
      logic [PIX_W-1:0] target;
      logic [PIX_W-1:0] hot;
      logic [PIX_W-1:0] cold;
   } cal_cfg_t;

   typedef struct packed {
      logic signed [FINE_W-1:0]   fine;
      logic signed [COARSE_W-1:0] coarse;
   } dac_pair_t;
endpackage

// File: hdl/optical_black_offset_calibration.sv
// Functional notes
// - after settling the offset dacs make the black output code equal the black level target.
// - black pixels form a weighted rolling average with weight 2^-k, smallest 1/128.
// - a larger weight converges faster and a smaller weight converges slower.
// - each black pixel after the first of a line is compared against the hot upper limit and the cold lower limit.
// - a pixel outside the limits is replaced by the previous black pixel.
// - with fast settle set, the first line of a frame ignores limits and uses weight 1.
// - black pixels averaged per line are 2^N with N from 0 to 6.
// - bypass stops auto updates and the dacs take software-written values.
// - leaving bypass, calibration starts from the dac values then held.
// - calibration starts when the clamp window goes low, sampled low on at least two successive rising clock edges.
// - the average is compared with the target (reset 40h) and the fine dac is corrected.
// - beyond the fine span of +-225 the coarse dac steps one lsb per adjustment by sign.
//
// The APB slave port and the address map are this design's own decisions.
`timescale 1ns/10ps
module optical_black_offset_calibration (
   input  wire logic                              i_ref_clk,
   input  wire logic                              i_sys_rst,
   input  wire logic                              i_black_clamp_window_n,
   input  wire logic                              i_frame_start,
   input  wire logic [ob_cal_pkg::PIX_W-1:0]      i_pixel_output_bus,
   input  wire logic                              i_psel,
   input  wire logic                              i_penable,
   input  wire logic                              i_pwrite,
   input  wire logic [7:0]                        i_paddr,
   input  wire logic [31:0]                       i_pwdata,
   output logic [31:0]                            o_prdata,
   output logic                                   o_pready,
   output logic                                   o_pslverr,
   output logic [ob_cal_pkg::FINE_W-1:0]          o_fine_offset_dac,
   output logic [ob_cal_pkg::COARSE_W-1:0]        o_coarse_offset_dac
);
   typedef enum {ST_IDLE, ST_ACC, ST_FILT, ST_ADJ} cal_state_t;

   ob_cal_pkg::cal_cfg_t  cfg, next_cfg;
   ob_cal_pkg::dac_pair_t dac, next_dac;
   cal_state_t            state, next_state;
   logic [31:0]           prdata, next_prdata;
   logic                  sync1, sync2, sync3, next_sync1;
   logic                  clamp_low, clamp_low_q;
   logic                  first_line, next_first_line;
   logic                  frame_pending, next_frame_pending;
   logic [6:0]            pix_cnt, next_pix_cnt;
   logic [ob_cal_pkg::PIX_W-1:0] prev_pix, next_prev_pix;
   logic [ob_cal_pkg::AVG_W-1:0] line_sum, next_line_sum;
   logic [ob_cal_pkg::AVG_W-1:0] avg, next_avg;
   logic                  avg_valid, next_avg_valid;
   logic [6:0]            npix;
   logic [ob_cal_pkg::PIX_W-1:0] pix_use, line_mean;
   logic signed [ob_cal_pkg::AVG_W+1:0] err, avg_delta;
   logic signed [ob_cal_pkg::FINE_W+1:0] fine_sum;
   logic                  wr, rd, fast;
   logic [2:0]            wshift;

   assign wr         = i_psel && i_penable && i_pwrite;
   assign rd         = i_psel && i_penable && !i_pwrite;
   assign o_pready   = 1'b1;
   assign o_prdata   = prdata;
   assign o_fine_offset_dac   = dac.fine;
   assign o_coarse_offset_dac = dac.coarse;
   // clamp low once second and third stages are both low
   assign clamp_low  = !sync2 && !sync3;
   assign npix       = 7'(1) << cfg.npix_log2;
   assign fast       = cfg.sof_fast && first_line;
   assign wshift     = fast ? 3'h0 : cfg.weight_shift;

   always_comb begin
      next_sync1 = i_black_clamp_window_n;
   end

   // pixel screen against hot and cold limits
   always_comb begin
      pix_use = i_pixel_output_bus;
      if (!fast && pix_cnt != 7'h0 &&
          (i_pixel_output_bus > cfg.hot || i_pixel_output_bus < cfg.cold)) begin
         pix_use = prev_pix;
      end
   end

   always_comb begin
      line_mean = ob_cal_pkg::PIX_W'(line_sum >> cfg.npix_log2);
      avg_delta = $signed({2'b00, line_mean, 7'h00}) - $signed({2'b00, avg});
      err       = $signed({2'b00, avg}) - $signed({2'b00, cfg.target, 7'h00});
      fine_sum  = $signed({{2{dac.fine[ob_cal_pkg::FINE_W-1]}}, dac.fine}) -
                  $signed(err[ob_cal_pkg::FINE_W+8:7]);
   end

   // calibration sequencer
   always_comb begin
      next_state         = state;
      next_pix_cnt       = pix_cnt;
      next_line_sum      = line_sum;
      next_prev_pix      = prev_pix;
      next_avg           = avg;
      next_avg_valid     = avg_valid;
      next_first_line    = first_line;
      next_frame_pending = frame_pending | i_frame_start;
      next_dac           = dac;
      case (state)
         ST_IDLE: begin
            if (clamp_low && !clamp_low_q) begin
               next_state         = ST_ACC;
               next_pix_cnt       = 7'h0;
               next_line_sum      = '0;
               next_first_line    = frame_pending;
               next_frame_pending = i_frame_start;
            end
         end
         ST_ACC: begin
            if (!clamp_low) begin
               next_state = ST_IDLE;
            end else begin
               next_line_sum = line_sum + ob_cal_pkg::AVG_W'(pix_use);
               next_prev_pix = pix_use;
               next_pix_cnt  = pix_cnt + 7'h1;
               if (pix_cnt + 7'h1 == npix) begin
                  next_state = ST_FILT;
               end
            end
         end
         ST_FILT: begin
            // avg += (mean - avg) * 2^-shift, first line seeds directly
            if (!avg_valid || wshift == 3'h0) begin
               next_avg = {line_mean, 7'h00};
            end else begin
               next_avg = ob_cal_pkg::AVG_W'($signed({2'b00, avg}) + (avg_delta >>> wshift));
            end
            next_avg_valid = 1'b1;
            next_state     = ST_ADJ;
         end
         ST_ADJ: begin
            if (!cfg.bypass) begin
               if (fine_sum > ob_cal_pkg::FINE_SPAN) begin
                  next_dac.fine   = 9'(ob_cal_pkg::FINE_SPAN);
                  next_dac.coarse = dac.coarse - 8'h01;
               end else if (fine_sum < -ob_cal_pkg::FINE_SPAN) begin
                  next_dac.fine   = 9'(-ob_cal_pkg::FINE_SPAN);
                  next_dac.coarse = dac.coarse + 8'h01;
               end else begin
                  next_dac.fine = ob_cal_pkg::FINE_W'(fine_sum);
               end
            end
            next_state = ST_IDLE;
         end
         default: next_state = ST_IDLE;
      endcase
      // software dac writes, taken in any mode over the sequencer; held values reused on leaving bypass
      if (wr && i_paddr == ob_cal_pkg::ADDR_FINE_DAC) begin
         next_dac.fine = i_pwdata[ob_cal_pkg::FINE_W-1:0];
      end
      if (wr && i_paddr == ob_cal_pkg::ADDR_COARSE_DAC) begin
         next_dac.coarse = i_pwdata[ob_cal_pkg::COARSE_W-1:0];
      end
   end

   // apb register file
   always_comb begin
      next_cfg    = cfg;
      next_prdata = prdata;
      if (wr) begin
         case (i_paddr)
            ob_cal_pkg::ADDR_CTRL:   next_cfg.bypass = i_pwdata[ob_cal_pkg::CTRL_BYPASS_BIT];
            ob_cal_pkg::ADDR_CTRL2: begin
               next_cfg.weight_shift = i_pwdata[ob_cal_pkg::CTRL2_WEIGHT_LSB +: 3];
               next_cfg.npix_log2    = (i_pwdata[ob_cal_pkg::CTRL2_NPIX_LSB +: 3] > ob_cal_pkg::NPIX_MAX) ?
                                       ob_cal_pkg::NPIX_MAX : i_pwdata[ob_cal_pkg::CTRL2_NPIX_LSB +: 3];
               next_cfg.sof_fast     = i_pwdata[ob_cal_pkg::CTRL2_SOF_BIT];
            end
            ob_cal_pkg::ADDR_TARGET: next_cfg.target = i_pwdata[ob_cal_pkg::PIX_W-1:0];
            ob_cal_pkg::ADDR_HOT:    next_cfg.hot    = i_pwdata[ob_cal_pkg::PIX_W-1:0];
            ob_cal_pkg::ADDR_COLD:   next_cfg.cold   = i_pwdata[ob_cal_pkg::PIX_W-1:0];
            default: ;
         endcase
      end
      if (i_psel && !i_penable && !i_pwrite) begin
         case (i_paddr)
            ob_cal_pkg::ADDR_CTRL:       next_prdata = {31'h0, cfg.bypass};
            ob_cal_pkg::ADDR_CTRL2:      next_prdata = {23'h0, cfg.sof_fast, 1'b0, cfg.npix_log2,
                                                        1'b0, cfg.weight_shift};
            ob_cal_pkg::ADDR_TARGET:     next_prdata = {22'h0, cfg.target};
            ob_cal_pkg::ADDR_HOT:        next_prdata = {22'h0, cfg.hot};
            ob_cal_pkg::ADDR_COLD:       next_prdata = {22'h0, cfg.cold};
            ob_cal_pkg::ADDR_FINE_DAC:   next_prdata = {23'h0, dac.fine};
            ob_cal_pkg::ADDR_COARSE_DAC: next_prdata = {24'h0, dac.coarse};
            ob_cal_pkg::ADDR_STATUS:     next_prdata = {28'h0, first_line, avg_valid,
                                                        state == ST_ACC, state != ST_IDLE};
            ob_cal_pkg::ADDR_AVERAGE:    next_prdata = {15'h0, avg};
            default:                     next_prdata = 32'h0;
         endcase
      end
   end

   always_comb begin
      o_pslverr = rd && (i_paddr > ob_cal_pkg::ADDR_AVERAGE || i_paddr[1:0] != 2'b00);
   end

   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         sync1         <= 1'b1;
         sync2         <= 1'b1;
         sync3         <= 1'b1;
         clamp_low_q   <= 1'b0;
         state         <= ST_IDLE;
         pix_cnt       <= 7'h0;
         line_sum      <= '0;
         prev_pix      <= '0;
         avg           <= '0;
         avg_valid     <= 1'b0;
         first_line    <= 1'b0;
         frame_pending <= 1'b0;
         dac           <= {ob_cal_pkg::FINE_RST, ob_cal_pkg::COARSE_RST};
         prdata        <= 32'h0;
         cfg           <= {1'b0, ob_cal_pkg::NPIX_RST, ob_cal_pkg::WEIGHT_RST, 1'b0,
                           ob_cal_pkg::TARGET_RST, ob_cal_pkg::HOT_RST, ob_cal_pkg::COLD_RST};
      end else begin
         sync1         <= next_sync1;
         sync2         <= sync1;
         sync3         <= sync2;
         clamp_low_q   <= clamp_low;
         state         <= next_state;
         pix_cnt       <= next_pix_cnt;
         line_sum      <= next_line_sum;
         prev_pix      <= next_prev_pix;
         avg           <= next_avg;
         avg_valid     <= next_avg_valid;
         first_line    <= next_first_line;
         frame_pending <= next_frame_pending;
         dac           <= next_dac;
         prdata        <= next_prdata;
         cfg           <= next_cfg;
      end
   end
endmodule // optical_black_offset_calibration

// File: tb/ob_cal_monitor.sv
`timescale 1ns/10ps
module ob_cal_monitor (
   input wire logic                               i_ref_clk,
   input wire logic                               i_sys_rst,
   input wire logic                               i_black_clamp_window_n,
   input wire logic                               i_psel,
   input wire logic                               i_penable,
   input wire logic                               i_pwrite,
   input wire logic [7:0]                         i_paddr,
   input wire logic [31:0]                        i_pwdata,
   input wire logic [31:0]                        o_prdata,
   input wire logic                               o_pslverr,
   input wire logic [ob_cal_pkg::FINE_W-1:0]      o_fine_offset_dac,
   input wire logic [ob_cal_pkg::COARSE_W-1:0]    o_coarse_offset_dac
);
   logic       byp;
   logic       next_byp;
   logic [3:0] hi_cnt;
   logic [3:0] next_hi_cnt;
   wire        acc  = i_psel && i_penable;
   wire        wr_f = acc && i_pwrite && i_paddr == ob_cal_pkg::ADDR_FINE_DAC;
   wire        wr_c = acc && i_pwrite && i_paddr == ob_cal_pkg::ADDR_COARSE_DAC;
   always_comb begin
      next_byp = byp;
      if (acc && i_pwrite && i_paddr == ob_cal_pkg::ADDR_CTRL)
         next_byp = i_pwdata[0];
      next_hi_cnt = (!i_black_clamp_window_n) ? 4'h0 : hi_cnt + {3'h0, hi_cnt != 4'hf};
   end
   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         byp <= 1'b0;
         hi_cnt <= 4'h0;
      end else begin
         byp <= next_byp;
         hi_cnt <= next_hi_cnt;
      end
   end
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_sys_rst);
   a_fine_write: assert property (wr_f |=> o_fine_offset_dac == $past(i_pwdata[8:0]))
      else $error("fine dac ignored write");
   a_coarse_write: assert property (wr_c |=> o_coarse_offset_dac == $past(i_pwdata[7:0]))
      else $error("coarse dac ignored write");
   a_bypass_hold: assert property (byp && !wr_f && !wr_c |=> $stable(o_fine_offset_dac) && $stable(o_coarse_offset_dac))
      else $error("dac moved in bypass");
   a_quiet_idle: assert property (hi_cnt > 4'h7 && !wr_f && !wr_c |=> $stable(o_fine_offset_dac) && $stable(o_coarse_offset_dac))
      else $error("dac moved outside line");
   a_fine_span: assert property (!byp && !wr_f |=> $stable(o_fine_offset_dac)
      || ($signed(o_fine_offset_dac) <= 225 && $signed(o_fine_offset_dac) >= -225))
      else $error("fine dac beyond span");
   a_coarse_step: assert property (!byp && !wr_c && !wr_f |=> $stable(o_coarse_offset_dac)
      || (o_coarse_offset_dac == $past(o_coarse_offset_dac) - 8'h01 && $signed(o_fine_offset_dac) == 225)
      || (o_coarse_offset_dac == $past(o_coarse_offset_dac) + 8'h01 && $signed(o_fine_offset_dac) == -225))
      else $error("coarse step wrong");
   a_slverr_read: assert property (o_pslverr |-> acc && !i_pwrite)
      else $error("slverr outside read");
   a_unmapped_read: assert property (acc && !i_pwrite && i_paddr > 8'h20 |-> o_pslverr && o_prdata == 32'h0)
      else $error("unmapped read answer wrong");
   c_sw_write: cover property (wr_f);
   c_coarse_step: cover property (!byp ##1 $changed(o_coarse_offset_dac));
   c_idle: cover property (hi_cnt == 4'hf);
endmodule // ob_cal_monitor
bind optical_black_offset_calibration ob_cal_monitor ob_cal_monitor_i (.i_ref_clk, .i_sys_rst,
   .i_black_clamp_window_n, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata,
   .o_pslverr, .o_fine_offset_dac, .o_coarse_offset_dac);

// File: tb/black_timing_model.sv
`timescale 1ns/10ps
module black_timing_model (
   input  wire logic       i_ref_clk,
   input  wire logic       i_sys_rst,
   input  wire logic       i_go,
   input  wire logic       i_sof,
   input  wire logic [7:0] i_len,
   input  wire logic [9:0] i_level,
   input  wire logic [9:0] i_bad,
   output logic            o_window_n,
   output logic            o_frame_start,
   output logic [9:0]      o_pixel,
   output logic            o_busy
);
   logic [7:0] cnt;
   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_window_n <= 1'b1;
         o_frame_start <= 1'b0;
         o_pixel <= 10'h155;
         o_busy <= 1'b0;
         cnt <= 8'h00;
      end else begin
         o_frame_start <= i_go && i_sof;
         o_pixel <= !o_busy ? ~o_pixel : (cnt == 8'h08 ? i_bad : i_level);
         if (i_go) begin
            o_busy <= 1'b1;
            cnt <= 8'h00;
         end else if (o_busy && o_window_n && cnt == 8'h00) begin
            o_window_n <= 1'b0;
            cnt <= 8'h01;
         end else if (!o_window_n) begin
            cnt <= cnt + 8'h01;
            o_window_n <= cnt == i_len;
         end else
            o_busy <= 1'b0;
      end
   end
endmodule // black_timing_model

// File: tb/tb.sv
`timescale 1ns/10ps
module tb;
   typedef struct packed {logic [9:0] lv; logic [8:0] f;} row_t;
   row_t       rows [7] = '{'{10'h044, 9'h1fc}, '{10'h03a, 9'h002}, '{10'h050, 9'h1f2},
      '{10'h030, 9'h002}, '{10'h041, 9'h001}, '{10'h03f, 9'h002}, '{10'h048, 9'h1fa}};
   logic       clk = 1'b0;
   logic       rst = 1'b1;
   logic       psel = 1'b0;
   logic       penable = 1'b0;
   logic       pwrite = 1'b0;
   logic       go = 1'b0;
   logic       sof = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [7:0] len = 8'h00;
   logic [9:0] level = 10'h000;
   logic [9:0] bad = 10'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd;
   logic [9:0] pix;
   logic [8:0] fine;
   logic [7:0] coarse;
   logic       win_n, fstart, mbusy, ready, slverr, err;
   int         num_errors = 0;
   int         n_checks = 0;
   always #4 clk = ~clk;
   optical_black_offset_calibration optical_black_offset_calibration_i (.i_ref_clk(clk), .i_sys_rst(rst),
      .i_black_clamp_window_n(win_n), .i_frame_start(fstart), .i_pixel_output_bus(pix), .i_psel(psel),
      .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
      .o_pready(ready), .o_pslverr(slverr), .o_fine_offset_dac(fine), .o_coarse_offset_dac(coarse));
   black_timing_model black_timing_model_i (.i_ref_clk(clk), .i_sys_rst(rst), .i_go(go), .i_sof(sof),
      .i_len(len), .i_level(level), .i_bad(bad), .o_window_n(win_n), .o_frame_start(fstart),
      .o_pixel(pix), .o_busy(mbusy));
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      for (k = 0; k < 20; k++) begin
         @(posedge clk);
         if (ready === 1'b1)
            break;
      end
      if (ready !== 1'b1) begin
         num_errors++;
         end_of_test();
      end
      rd = prdata;
      err = slverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(nm, e, rd);
   endtask
   task automatic line(input logic s, input logic [9:0] l, input logic [9:0] b, input int n);
      int k;
      sof <= s;
      level <= l;
      bad <= b;
      len <= 8'(2 ** n + 8);
      go <= 1'b1;
      @(posedge clk) go <= 1'b0;
      for (k = 0; k < 300; k++) begin
         @(negedge clk);
         if (k > 1 && mbusy === 1'b0)
            break;
      end
      if (k == 300) begin
         num_errors++;
         end_of_test();
      end
      repeat (8) @(posedge clk);
   endtask
   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      rdchk("target", ob_cal_pkg::ADDR_TARGET, 32'h40);
      rdchk("hot", ob_cal_pkg::ADDR_HOT, 32'h3ff);
      rdchk("ctrl2", ob_cal_pkg::ADDR_CTRL2, 32'h40);
      apb(1'b0, 8'h24, 32'h0);
      chk("slverr", 32'h1, {31'h0, err});
      $display("test reset done");
      apb(1'b1, ob_cal_pkg::ADDR_HOT, 32'h200);
      apb(1'b1, ob_cal_pkg::ADDR_COLD, 32'h10);
      for (int i = 0; i < 7; i++) begin
         apb(1'b1, ob_cal_pkg::ADDR_CTRL2, 32'(i) << 4);
         line(1'b0, rows[i].lv, i[0] ? 10'h3f0 : 10'h005, i);
         rdchk("avg", ob_cal_pkg::ADDR_AVERAGE, 32'(rows[i].lv) << 7);
         chk("fine", 32'(rows[i].f), 32'(fine));
      end
      $display("test rows done");
      apb(1'b1, ob_cal_pkg::ADDR_CTRL2, 32'h41);
      line(1'b0, 10'h058, 10'h058, 4);
      rdchk("avg_half", ob_cal_pkg::ADDR_AVERAGE, 32'h2800);
      apb(1'b1, ob_cal_pkg::ADDR_CTRL2, 32'h47);
      line(1'b0, 10'h0d0, 10'h0d0, 4);
      rdchk("avg_slow", ob_cal_pkg::ADDR_AVERAGE, 32'h2880);
      apb(1'b1, ob_cal_pkg::ADDR_CTRL2, 32'h147);
      line(1'b1, 10'h030, 10'h3f0, 4);
      rdchk("avg_sof", ob_cal_pkg::ADDR_AVERAGE, 32'h3600);
      $display("test weight done");
      apb(1'b1, ob_cal_pkg::ADDR_CTRL, 32'h1);
      apb(1'b1, ob_cal_pkg::ADDR_FINE_DAC, 32'h0a0);
      apb(1'b1, ob_cal_pkg::ADDR_COARSE_DAC, 32'h05);
      line(1'b0, 10'h080, 10'h080, 4);
      chk("byp_fine", 32'h0a0, 32'(fine));
      chk("byp_coarse", 32'h05, 32'(coarse));
      apb(1'b1, ob_cal_pkg::ADDR_FINE_DAC, 32'h0a0);
      chk("fine_only_coarse", 32'h05, 32'(coarse));
      apb(1'b1, ob_cal_pkg::ADDR_CTRL2, 32'h40);
      apb(1'b1, ob_cal_pkg::ADDR_CTRL, 32'h0);
      line(1'b0, 10'h041, 10'h041, 4);
      chk("resume_fine", 32'h09f, 32'(fine));
      repeat (3) line(1'b0, 10'h020, 10'h020, 4);
      chk("clamp_fine", 32'h0e1, 32'(fine));
      chk("clamp_coarse", 32'h04, 32'(coarse));
      $display("test bypass done");
      end_of_test();
   end
endmodule // tb
